// ==== core/rsc_reset_ctrl.v ====
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "rsc_regs.vh"
module rsc_reset_ctrl #(
	parameter WARMUP_CYC = `RSC_WARMUP_CYC
) (
	// clock, reset, enable
	input  wire        pclk,
	input  wire        presetn,
	input  wire        clk_en,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [13:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// reset sources
	input  wire        por_active,
	input  wire        wdt_overflow,
	input  wire        clk_deadlock,
	input  wire        flash_standby_access,
	input  wire        trim_corrupt,
	input  wire        det1_below,
	input  wire        det2_below,
	// trim load from non-volatile store
	input  wire        trim_load_done,
	input  wire        trim_load_bad,
	// shared pin
	input  wire        shared_reset_port_pin_i,
	input  wire        port_out_val,
	output reg         shared_reset_port_pin_o,
	output reg         shared_reset_port_pin_oe,
	// outputs to system
	output reg         core_reset_n,
	output reg         warmup_active,
	output reg         trim_load_req,
	output reg         low_voltage_irq,
	output reg         ram_map_sel,
	output reg         vector_map_sel
);

// =============================================================
// state and storage
// =============================================================
localparam ST_RESET  = 2'd0;
localparam ST_WARMUP = 2'd1;
localparam ST_RUN    = 2'd2;

reg  [1:0]  state_ff;
reg  [1:0]  nxt_state;
reg  [15:0] wcnt_ff;
reg  [15:0] nxt_wcnt;
reg  [1:0]  hard_sync_ff;
reg  [6:0]  cause_ff;
reg  [6:0]  nxt_cause;
reg         fclr_ff;
reg         rstdis_wr_ff;
reg         rstdis_act_ff;
reg         rarea_wr_ff;
reg         rvctr_wr_ff;
reg         rarea_act_ff;
reg         rvctr_act_ff;
reg  [1:0]  lvl1_ff;
reg  [1:0]  lvl2_ff;
reg         det1f_ff;
reg         det2f_ff;
reg  [3:0]  supply_monitor_mode_ctrl_ff;
reg         soft_int_ff;
reg         pin_dir_ff;
reg         por_seen_ff;

wire wr_acc = psel & penable & pwrite;
wire rd_acc = psel & penable & ~pwrite;
wire [7:0] wbyte = pwdata[7:0];

// detector reset requests, gated by enable and reset mode; detector 2 is also gated by detector 1 enable (bit 0)
wire det1_rst = supply_monitor_mode_ctrl_ff[0] & supply_monitor_mode_ctrl_ff[1] & det1_below;
wire det2_rst = supply_monitor_mode_ctrl_ff[2] & supply_monitor_mode_ctrl_ff[3] & supply_monitor_mode_ctrl_ff[0] & det2_below;
wire trim_rst = trim_corrupt & (state_ff == ST_RUN);
wire int_rst  = wdt_overflow | clk_deadlock | flash_standby_access
	| trim_rst | det1_rst | det2_rst;

// pin acts as reset input unless port function was activated
wire pin_is_reset = ~rstdis_act_ff;
// hard reset: power-on or pin low, ORed
wire hard_rst = por_active | (pin_is_reset & ~shared_reset_port_pin_i);
wire hard_held = hard_sync_ff[1];

// =============================================================
// reset release synchroniser
// =============================================================
// hard reset is level-synchronised; release seen two edges late
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		hard_sync_ff <= 2'b11;
	end else if (clk_en) begin
		hard_sync_ff <= {hard_sync_ff[0], hard_rst};
	end
end

// =============================================================
// warm-up sequencer
// =============================================================
// any reset cause returns to ST_RESET, which zeroes the counter
always @* begin
	nxt_state = state_ff;
	nxt_wcnt  = wcnt_ff;
	case (state_ff)
	ST_RESET: begin
		nxt_wcnt = 16'h0000;
		if (!hard_held && !int_rst && !soft_int_ff) begin
			nxt_state = ST_WARMUP;
		end
	end
	ST_WARMUP: begin
		if (hard_held || int_rst) begin
			nxt_state = ST_RESET;
			nxt_wcnt  = 16'h0000;
		end else if (wcnt_ff == WARMUP_CYC[15:0] - 16'h0001) begin
			nxt_state = ST_RUN;
		end else begin
			nxt_wcnt = wcnt_ff + 16'h0001;
		end
	end
	ST_RUN: begin
		// software-triggered reset re-runs warm-up and the trim load
		if (hard_held || int_rst || soft_int_ff) begin
			nxt_state = ST_RESET;
		end
	end
	default: begin
		nxt_state = ST_RESET;
	end
	endcase
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		state_ff <= ST_RESET;
		wcnt_ff  <= 16'h0000;
	end else if (clk_en) begin
		state_ff <= nxt_state;
		wcnt_ff  <= nxt_wcnt;
	end
end

// =============================================================
// cause flags
// =============================================================
// flags are cleared only by hard reset or keyed clear; set wins over keyed clear, hard reset wins over set
always @* begin
	nxt_cause = cause_ff;
	if (wr_acc && paddr == `RSC_ADDR_KEY && wbyte == `RSC_KEY_CLR && fclr_ff) begin
		nxt_cause = 7'h00;
	end
	if (wdt_overflow) nxt_cause[`RSC_B_WDT] = 1'b1;
	if (clk_deadlock) nxt_cause[`RSC_B_CLK] = 1'b1;
	if (det1_rst) nxt_cause[`RSC_B_DET1] = 1'b1;
	if (det2_rst) nxt_cause[`RSC_B_DET2] = 1'b1;
	if (trim_rst) nxt_cause[`RSC_B_TRIMRST] = 1'b1;
	if (flash_standby_access) nxt_cause[`RSC_B_FLASH] = 1'b1;
	if (state_ff == ST_WARMUP && trim_load_done && trim_load_bad) begin
		nxt_cause[`RSC_B_TRIMBAD] = 1'b1;
	end
	if (hard_held) nxt_cause = 7'h00;
end

// internal resets never clear the flags
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		cause_ff <= 7'h00;
	end else if (clk_en) begin
		cause_ff <= nxt_cause;
	end
end

// =============================================================
// apb register writes
// =============================================================
// syscfg and clear-enable values drop on any reset, detector settings on hard reset; activated disable only on power-on
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		fclr_ff       <= 1'b0;
		rstdis_wr_ff  <= 1'b0;
		rstdis_act_ff <= 1'b0;
		rarea_wr_ff   <= 1'b0;
		rvctr_wr_ff   <= 1'b0;
		rarea_act_ff  <= 1'b0;
		rvctr_act_ff  <= 1'b0;
		lvl1_ff       <= 2'b00;
		lvl2_ff       <= 2'b00;
		det1f_ff      <= 1'b0;
		det2f_ff      <= 1'b0;
		supply_monitor_mode_ctrl_ff      <= 4'h0;
		soft_int_ff   <= 1'b0;
		pin_dir_ff    <= 1'b0;
		por_seen_ff   <= 1'b1;
	end else if (clk_en) begin
		por_seen_ff <= por_active;
		soft_int_ff <= 1'b0;
		if (por_seen_ff) begin
			rstdis_act_ff <= 1'b0;
		end
		if (state_ff != ST_RUN) begin
			fclr_ff      <= 1'b0;
			rstdis_wr_ff <= 1'b0;
			rarea_wr_ff  <= 1'b0;
			rvctr_wr_ff  <= 1'b0;
			pin_dir_ff   <= 1'b0;
		end else if (wr_acc) begin
			if (paddr == `RSC_ADDR_CAUSE) begin
				fclr_ff <= wbyte[`RSC_B_FCLR];
			end else if (paddr == `RSC_ADDR_SYSCFG) begin
				rstdis_wr_ff <= wbyte[0];
				rarea_wr_ff  <= wbyte[1];
				rvctr_wr_ff  <= wbyte[2];
				pin_dir_ff   <= wbyte[3];
			end else if (paddr == `RSC_ADDR_KEY) begin
				// other codes ignored
				if (wbyte == `RSC_KEY_RSTDIS && !por_seen_ff) begin
					rstdis_act_ff <= rstdis_wr_ff;
				end else if (wbyte == `RSC_KEY_MAP) begin
					rarea_act_ff <= rarea_wr_ff;
					rvctr_act_ff <= rvctr_wr_ff;
				end else if (wbyte == `RSC_KEY_CLR && fclr_ff) begin
					fclr_ff <= 1'b0;
				end
			end else if (paddr == `RSC_ADDR_MONCTL) begin
				lvl1_ff <= wbyte[1:0];
				lvl2_ff <= wbyte[5:4];
				if (!wbyte[3]) det1f_ff <= 1'b0;
				if (!wbyte[7]) det2f_ff <= 1'b0;
			end else if (paddr == `RSC_ADDR_MONMODE) begin
				supply_monitor_mode_ctrl_ff <= wbyte[3:0];
			end else if (paddr == `RSC_ADDR_STAT && wbyte[0]) begin
				soft_int_ff <= 1'b1; // software-triggered internal reset
			end
		end
		// detector flags: set wins over software clear
		if (supply_monitor_mode_ctrl_ff[0] && det1_below) det1f_ff <= 1'b1;
		if (supply_monitor_mode_ctrl_ff[2] && det2_below) det2f_ff <= 1'b1;
		// detector settings drop on hard reset only
		if (hard_held) begin
			lvl1_ff  <= 2'b00;
			lvl2_ff  <= 2'b00;
			det1f_ff <= 1'b0;
			det2f_ff <= 1'b0;
			supply_monitor_mode_ctrl_ff <= 4'h0;
		end
	end
end

// =============================================================
// apb read and response
// =============================================================
// zero-wait slave; unmapped addresses answer pslverr
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		prdata  <= 32'h0000_0000;
		pready  <= 1'b0;
		pslverr <= 1'b0;
	end else if (clk_en) begin
		pready  <= psel & ~penable;
		pslverr <= 1'b0;
		prdata  <= 32'h0000_0000;
		if (psel && !penable) begin
			if (paddr == `RSC_ADDR_CAUSE) begin
				prdata <= {25'h0, cause_ff}; // bit 7 reads zero
			end else if (paddr == `RSC_ADDR_MONCTL) begin
				prdata <= {24'h0, det2f_ff, det2_below & supply_monitor_mode_ctrl_ff[2], lvl2_ff,
					det1f_ff, det1_below & supply_monitor_mode_ctrl_ff[0], lvl1_ff};
			end else if (paddr == `RSC_ADDR_MONMODE) begin
				prdata <= {28'h0, supply_monitor_mode_ctrl_ff};
			end else if (paddr == `RSC_ADDR_SYSCFG) begin
				prdata <= {28'h0, pin_dir_ff, rvctr_wr_ff, rarea_wr_ff, rstdis_wr_ff};
			end else if (paddr == `RSC_ADDR_KEY) begin
				prdata <= {29'h0, rvctr_act_ff, rarea_act_ff, rstdis_act_ff};
			end else if (paddr == `RSC_ADDR_STAT) begin
				prdata <= {30'h0, state_ff};
			end else begin
				pslverr <= 1'b1;
			end
		end
	end
end

// =============================================================
// system outputs
// =============================================================
// pin as port is open-drain: drive low only, never high
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		core_reset_n             <= 1'b0;
		warmup_active            <= 1'b0;
		trim_load_req            <= 1'b0;
		low_voltage_irq          <= 1'b0;
		ram_map_sel              <= 1'b0;
		vector_map_sel           <= 1'b0;
		shared_reset_port_pin_o  <= 1'b0;
		shared_reset_port_pin_oe <= 1'b0;
	end else if (clk_en) begin
		core_reset_n    <= (nxt_state == ST_RUN);
		warmup_active   <= (nxt_state == ST_WARMUP);
		trim_load_req   <= (nxt_state == ST_WARMUP);
		low_voltage_irq <= (supply_monitor_mode_ctrl_ff[0] & ~supply_monitor_mode_ctrl_ff[1] & det1_below)
			| (supply_monitor_mode_ctrl_ff[2] & ~supply_monitor_mode_ctrl_ff[3] & det2_below);
		ram_map_sel     <= rarea_act_ff;
		vector_map_sel  <= rvctr_act_ff;
		shared_reset_port_pin_o  <= 1'b0;
		shared_reset_port_pin_oe <= rstdis_act_ff & pin_dir_ff & ~port_out_val;
	end
end

endmodule // rsc_reset_ctrl

// ==== include/rsc_regs.vh ====
`ifndef RSC_REGS_VH
`define RSC_REGS_VH
// register byte addresses; printed offsets are not all multiples of four, so index*4
`define RSC_IDX_MONCTL     12'hfc6
`define RSC_IDX_MONMODE    12'hfc7
`define RSC_IDX_CAUSE      12'hfcc
`define RSC_IDX_SYSCFG     12'hfde
`define RSC_IDX_KEY        12'hfdf
`define RSC_IDX_STAT       12'hfe0
`define RSC_ADDR_MONCTL    14'h3f18
`define RSC_ADDR_MONMODE   14'h3f1c
`define RSC_ADDR_CAUSE     14'h3f30
`define RSC_ADDR_SYSCFG    14'h3f78
`define RSC_ADDR_KEY       14'h3f7c
`define RSC_ADDR_STAT      14'h3f80
// key codes
`define RSC_KEY_RSTDIS     8'hb2
`define RSC_KEY_MAP        8'hd4
`define RSC_KEY_CLR        8'h71
// cause register bit positions
`define RSC_B_WDT          0
`define RSC_B_CLK          1
`define RSC_B_DET1         2
`define RSC_B_DET2         3
`define RSC_B_TRIMRST      4
`define RSC_B_TRIMBAD      5
`define RSC_B_FLASH        6
`define RSC_B_FCLR         7
// reset values
`define RSC_RST_BYTE       8'h00
// warm-up time in cycles of the high-frequency clock (plain default)
`define RSC_WARMUP_CYC     16384
`endif

// ==== tb/rsc_board_rst.sv ====
`timescale 1ns/1ns
// ==========
// board reset supervisor
module rsc_board_rst #(
	parameter int LOW_CYC = 250
) (
	// control
	input  wire logic pclk,
	input  wire logic req,
	// wire
	input  wire logic pin_oe,
	output logic      pin
);
	int cnt = 0;
	// low time is stretched to the minimum after every request
	always @(posedge pclk) cnt <= req ? LOW_CYC : (cnt > 0 ? cnt - 1 : 0);
	// pull-up wins once nobody pulls low
	assign pin = !(pin_oe || req || cnt > 0);
endmodule // rsc_board_rst

// ==== tb/rsc_reset_ctrl_assertions.sv ====
`timescale 1ns/1ns
// ==========
// reset checker
module rsc_reset_ctrl_chk #(
	parameter WARMUP_CYC = 8
) (
	// clock, reset
	input wire pclk,
	input wire presetn,
	// causes
	input wire por_active,
	input wire wdt_overflow,
	input wire clk_deadlock,
	input wire flash_standby_access,
	input wire trim_corrupt,
	input wire shared_reset_port_pin_i,
	// state
	input wire core_reset_n,
	input wire warmup_active,
	input wire trim_load_req
);
	logic [15:0] wcnt_ff;
	// length of the current warm-up run
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) wcnt_ff <= 16'h0000;
		else wcnt_ff <= warmup_active ? wcnt_ff + 16'h0001 : 16'h0000;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// sync stages plus state change
	sequence s_core_down;
		##[1:5] !core_reset_n;
	endsequence
	chk_por_holds: assert property (por_active |-> s_core_down)
		else $error("core ran during power-on");
	chk_pin_resets: assert property (!shared_reset_port_pin_i |-> s_core_down)
		else $error("pin low did not reset");
	// the sampled count already includes the last warm-up cycle
	chk_warm_len: assert property ($rose(core_reset_n) |-> wcnt_ff + 16'h0001 >= WARMUP_CYC)
		else $error("warm-up cut short");
	chk_trim_load: assert property (trim_load_req == warmup_active)
		else $error("trim load outside warm-up");
	chk_wdt_reset: assert property (wdt_overflow && core_reset_n |-> s_core_down)
		else $error("no watchdog reset");
	chk_clk_reset: assert property (clk_deadlock && core_reset_n |-> s_core_down)
		else $error("no deadlock reset");
	chk_flash_reset: assert property (flash_standby_access && core_reset_n |-> s_core_down)
		else $error("no flash reset");
	chk_trim_reset: assert property (trim_corrupt && core_reset_n |-> s_core_down)
		else $error("no trim reset");
endmodule // rsc_reset_ctrl_chk
bind rsc_reset_ctrl rsc_reset_ctrl_chk #(.WARMUP_CYC(WARMUP_CYC)) u_chk (
	.pclk(pclk), .presetn(presetn), .por_active(por_active), .wdt_overflow(wdt_overflow),
	.clk_deadlock(clk_deadlock), .flash_standby_access(flash_standby_access),
	.trim_corrupt(trim_corrupt), .shared_reset_port_pin_i(shared_reset_port_pin_i),
	.core_reset_n(core_reset_n), .warmup_active(warmup_active), .trim_load_req(trim_load_req));

// ==== tb/tb_reset_source_control.sv ====
`timescale 1ns/1ns
`include "rsc_regs.vh"
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
	$display("Error %s expected %h seen %h", n, e, a); end end
// ==========
// bench top
module tb_reset_source_control;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        por = 0, bad = 0, req = 1, pin;
	logic [13:0] paddr = 14'h0000;
	logic [31:0] pwdata = 32'h0, seed = 32'h1def;
	logic [5:0]  src = 6'h00;
	logic [7:0]  exp_c = 8'h00;
	logic [9:0]  q[$], e_n;
	wire  [31:0] prdata;
	wire         pready, pslverr, pin_oe, core_n, warm, irq;
	int          error_cnt = 0, checks_done = 0;
	int          bitpos[6] = '{0, 1, 6, 4, 2, 3};
	always #10 pclk = ~pclk;
	rsc_reset_ctrl #(.WARMUP_CYC(8)) u_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .por_active(por),
		.wdt_overflow(src[0]), .clk_deadlock(src[1]), .flash_standby_access(src[2]),
		.trim_corrupt(src[3]), .det1_below(src[4]), .det2_below(src[5]),
		.trim_load_done(1'b1), .trim_load_bad(bad), .shared_reset_port_pin_i(pin),
		.port_out_val(1'b0), .shared_reset_port_pin_o(), .shared_reset_port_pin_oe(pin_oe),
		.core_reset_n(core_n), .warmup_active(warm), .trim_load_req(), .low_voltage_irq(irq),
		.ram_map_sel(), .vector_map_sel());
	rsc_board_rst #(.LOW_CYC(250)) u_brd (.pclk(pclk), .req(req), .pin_oe(pin_oe), .pin(pin));
	function logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// one apb transfer; e holds read flag, error and data
	task apb(input logic w, input logic [13:0] a, input logic [7:0] d, input logic [9:0] e);
		@(posedge pclk);
		q.push_back(e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [13:0] a, input logic [7:0] d); apb(1'b1, a, d, 10'h000); endtask
	task rd(input logic [13:0] a, input logic [7:0] d); apb(1'b0, a, 8'h00, {2'b10, d}); endtask
	// lets the request land, then waits out the warm-up
	task run_wait;
		repeat (6) @(posedge pclk);
		repeat (800) if (core_n !== 1'b1) @(posedge pclk);
	endtask
	task pulse(input int i);
		@(posedge pclk);
		src[i] <= 1'b1;
		repeat (1 + seed[1:0]) @(posedge pclk);
		src[i] <= 1'b0;
		run_wait();
	endtask
	task results;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// response monitor; upper read bits must be zero
	always @(posedge pclk) begin
		if (pready === 1'b1) begin
			e_n = q.pop_front();
			if (e_n[9]) `CHK("read", {e_n[8], 24'h0, e_n[7:0]}, {pslverr, prdata})
			else `CHK("response", e_n[8], pslverr)
		end
	end
	// main sequence: slow supply holds the pin low past power-up
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (20) @(posedge pclk);
		`CHK("held by pin", 1'b0, core_n)
		req <= 1'b0;
		run_wait();
		`CHK("running", 1'b1, core_n)
		rd(`RSC_ADDR_CAUSE, 8'h00);
		wr(`RSC_ADDR_MONMODE, 8'h0f);
		apb(1'b1, 14'h3f04, 8'h5a, 10'h100);
		for (int i = 0; i < 6; i++) begin
			seed = xs(seed);
			pulse(i);
			exp_c[bitpos[i]] = 1'b1;
			rd(`RSC_ADDR_CAUSE, exp_c);
		end
		bad <= 1'b1;
		wr(`RSC_ADDR_STAT, 8'h01);
		run_wait();
		bad <= 1'b0;
		exp_c[5] = 1'b1;
		rd(`RSC_ADDR_CAUSE, exp_c);
		wr(`RSC_ADDR_CAUSE, 8'h80);
		seed = xs(seed);
		wr(`RSC_ADDR_KEY, seed[7:0] inside {8'hb2, 8'hd4, 8'h71} ? 8'h00 : seed[7:0]);
		rd(`RSC_ADDR_CAUSE, exp_c);
		wr(`RSC_ADDR_KEY, `RSC_KEY_CLR);
		rd(`RSC_ADDR_CAUSE, 8'h00);
		pulse(0);
		wr(`RSC_ADDR_KEY, `RSC_KEY_CLR);
		rd(`RSC_ADDR_CAUSE, 8'h01);
		wr(`RSC_ADDR_MONMODE, 8'h05);
		src[5] <= 1'b1;
		repeat (6) @(posedge pclk);
		`CHK("irq mode", 2'b11, {irq, core_n})
		src[5] <= 1'b0;
		req <= 1'b1;
		@(posedge pclk);
		req <= 1'b0;
		run_wait();
		rd(`RSC_ADDR_CAUSE, 8'h00);
		rd(`RSC_ADDR_MONMODE, 8'h00);
		por <= 1'b1;
		repeat (20) @(posedge pclk);
		`CHK("power-on hold", 1'b0, core_n)
		por <= 1'b0;
		run_wait();
		rd(`RSC_ADDR_CAUSE, 8'h00);
		repeat (4) @(posedge pclk);
		results();
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		results();
	end
endmodule // tb_reset_source_control
